/* design/lfr_legacy_flags.sv */
// legacy flags application register with fixed and reserved bit handling
`timescale 1ns/10ps
module lfr_legacy_flags
  import lfr_pkg::*;
#(
  // 1: native writes to fixed bits are stored; 0: ignored
  parameter bit NATIVE_STORE_FIXED = 1'h0,
  // 1: native reserved writes stored; 0: fault on non-zero
  parameter bit NATIVE_STORE_RSVD = 1'h0
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // instruction access
  input wire lfr_req_t req,
  output logic [63:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic legacy_exception_fault_ff,
  output logic reserved_field_fault_ff,
  // legacy execution results
  input wire logic arith_upd,
  input wire lfr_arith_t arith_in,
  input wire logic legacy_mode,
  output lfr_steer_t steer_ff
);
  // flag storage, kept across instruction set transitions
  logic [63:0] flags_ff;
  logic [63:0] nxt_flags;
  // read response
  logic [63:0] nxt_rd_data;
  logic nxt_rd_valid;
  // fault pulses
  logic nxt_gp;
  logic nxt_rsv;
  // legacy steering
  lfr_steer_t nxt_steer;
  // write decode
  logic wr_bad;
  logic leg_store;
  logic nat_store;

  // arithmetic results placed at their register positions
  function automatic logic [63:0] pack_arith(input lfr_arith_t a);
    logic [63:0] v;
    v = 64'h0;
    v[CARRY_BIT] = a.carry_flag;
    v[PARITY_BIT] = a.parity_flag;
    v[AUX_BIT] = a.auxiliary_carry_flag;
    v[ZERO_FLAG_BIT] = a.zero_flag;
    v[SIGN_BIT] = a.sign_flag;
    v[DIR_BIT] = a.direction_flag;
    v[OVF_BIT] = a.overflow_flag;
    return v;
  endfunction

  // any set bit in the reserved field
  function automatic logic rsvd_hit(input logic [63:0] d);
    return (d & RSVD_MASK) != 64'h0;
  endfunction

  // fixed bits below the reserved field
  function automatic logic [63:0] low_fixed();
    return FIXED_MASK & ~RSVD_MASK;
  endfunction

  // keep the bits selected by keep, take the rest from d
  function automatic logic [63:0] merge(
    input logic [63:0] old_v,
    input logic [63:0] d,
    input logic [63:0] keep
  );
    // one expression serves writes and arithmetic updates alike
    return (old_v & keep) | (d & ~keep);
  endfunction

  // value that an access of either instruction set reads back
  function automatic logic [63:0] read_view(
    input logic [63:0] f,
    input logic nat
  );
    logic [63:0] v;
    v = f;
    // legacy reads always mask; native reads mask by option
    if (!nat)
      v = (f & ~FIXED_MASK) | ONES_VAL;
    else
    begin
      if (!NATIVE_STORE_FIXED)
        v = (v & ~low_fixed()) | ONES_VAL;
      if (!NATIVE_STORE_RSVD)
        v = v & ~RSVD_MASK;
    end
    return v;
  endfunction

  // flags handed to legacy logic; all clear outside legacy execution
  function automatic lfr_steer_t steer_view(
    input logic [63:0] f,
    input logic on
  );
    lfr_steer_t s;
    s = '0;
    if (on)
    begin
      s.direction_flag = f[DIR_BIT];
      s.carry_flag = f[CARRY_BIT];
      s.zero_flag = f[ZERO_FLAG_BIT];
      s.sign_flag = f[SIGN_BIT];
      s.overflow_flag = f[OVF_BIT];
      s.parity_flag = f[PARITY_BIT];
      s.io_privilege = f[IOPL_LO+:2];
      s.trap_flag = f[TRAP_BIT];
      s.int_enable = f[INT_EN_BIT];
    end
    return s;
  endfunction

  // a rejected write changes nothing but raises a fault
  assign wr_bad = req.wr && rsvd_hit(req.data);
  assign leg_store = req.wr && !req.native && !wr_bad;
  assign nat_store = req.wr && req.native
    && (NATIVE_STORE_RSVD || !wr_bad);

  // flag group: a write takes precedence over an arithmetic update
  always_comb
  begin
    nxt_flags = flags_ff;
    if (leg_store)
      nxt_flags = merge(flags_ff, req.data, FIXED_MASK);
    else if (nat_store && NATIVE_STORE_FIXED)
      nxt_flags = req.data;
    else if (nat_store)
      nxt_flags = merge(flags_ff, req.data,
        low_fixed());
    else if (!req.wr && arith_upd && legacy_mode)
      nxt_flags = merge(flags_ff, pack_arith(arith_in),
        ~ARITH_MASK);
  end

  // reset value has the always-one bit set
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      flags_ff <= RESET_VAL;
    else
      flags_ff <= nxt_flags;
  end

  // read data group: holds until the next read
  always_comb
  begin
    nxt_rd_data = rd_data_ff;
    if (req.rd)
      nxt_rd_data = read_view(flags_ff, req.native);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rd_data_ff <= 64'h0;
    else
      rd_data_ff <= nxt_rd_data;
  end

  // read valid group: one pulse per read
  always_comb
  begin
    nxt_rd_valid = req.rd;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rd_valid_ff <= 1'h0;
    else
      rd_valid_ff <= nxt_rd_valid;
  end

  // legacy fault group: one-cycle pulse
  always_comb
  begin
    nxt_gp = 1'h0;
    if (wr_bad && !req.native)
      nxt_gp = 1'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      legacy_exception_fault_ff <= 1'h0;
    else
      legacy_exception_fault_ff <= nxt_gp;
  end

  // native reserved fault group: only when storing is not chosen
  always_comb
  begin
    nxt_rsv = 1'h0;
    if (wr_bad && req.native && !NATIVE_STORE_RSVD)
      nxt_rsv = 1'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      reserved_field_fault_ff <= 1'h0;
    else
      reserved_field_fault_ff <= nxt_rsv;
  end

  // steer group: follows the value the flags take this edge
  always_comb
  begin
    nxt_steer = steer_view(nxt_flags, legacy_mode);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      steer_ff <= '0;
    else
      steer_ff <= nxt_steer;
  end
endmodule

/* design/lfr_pkg.sv */
// package for the legacy flags application register
package lfr_pkg;
  localparam int LFR_W = 64;
  localparam int CARRY_BIT = 0;
  localparam int ONE_BIT = 1;
  localparam int PARITY_BIT = 2;
  localparam int ZERO3_BIT = 3;
  localparam int AUX_BIT = 4;
  localparam int ZERO5_BIT = 5;
  localparam int ZERO_FLAG_BIT = 6;
  localparam int SIGN_BIT = 7;
  localparam int TRAP_BIT = 8;
  localparam int INT_EN_BIT = 9;
  localparam int DIR_BIT = 10;
  localparam int OVF_BIT = 11;
  localparam int IOPL_LO = 12;
  localparam int NESTED_BIT = 14;
  localparam int ZERO15_BIT = 15;
  localparam int RESUME_BIT = 16;
  localparam int V86_BIT = 17;
  localparam int ALIGN_BIT = 18;
  localparam int VINT_BIT = 19;
  localparam int VPEND_BIT = 20;
  localparam int PROBE_BIT = 21;
  localparam int RSVD_LO = 22;
  // arithmetic flag group update mask
  localparam logic [63:0] ARITH_MASK = 64'h0000_0000_0000_0CD5;
  // bits whose legacy read value is fixed or reserved
  localparam logic [63:0] FIXED_MASK = 64'hFFFF_FFFF_FFC0_802A;
  localparam logic [63:0] RSVD_MASK = 64'hFFFF_FFFF_FFC0_0000;
  localparam logic [63:0] ONES_VAL = 64'h0000_0000_0000_0002;
  localparam logic [63:0] RESET_VAL = 64'h0000_0000_0000_0002;
  // arithmetic flag results from the legacy execution unit
  typedef struct packed {
    logic overflow_flag;
    logic direction_flag;
    logic sign_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } lfr_arith_t;
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic native;
    logic [63:0] data;
  } lfr_req_t;
  // steering outputs to legacy logic
  typedef struct packed {
    logic direction_flag;
    logic carry_flag;
    logic zero_flag;
    logic sign_flag;
    logic overflow_flag;
    logic parity_flag;
    logic [1:0] io_privilege;
    logic trap_flag;
    logic int_enable;
  } lfr_steer_t;
endpackage

/* bench/lfr_legacy_flags_assertions.sv */
// port assertions for the legacy flags register
`timescale 1ns/10ps
module lfr_legacy_flags_assertions
  import lfr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire lfr_req_t req,
  input wire logic [63:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic legacy_exception_fault_ff,
  input wire logic reserved_field_fault_ff,
  input wire logic arith_upd,
  input wire lfr_arith_t arith_in,
  input wire logic legacy_mode,
  input wire lfr_steer_t steer_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence bad_lw; req.wr && !req.native && |req.data[63:22]; endsequence
  sequence bad_nw; req.wr && req.native && |req.data[63:22]; endsequence
  sequence arith_take; arith_upd && legacy_mode && !req.wr; endsequence
  arith_steer_a: assert property (arith_take |=>
    steer_ff.carry_flag == $past(arith_in.carry_flag))
    else $error("steer stale");
  rd_answer_a: assert property (req.rd |=> rd_valid_ff)
    else $error("read lost");
  no_stray_a: assert property (!req.rd |=> !rd_valid_ff)
    else $error("stray valid");
  one_bit_a: assert property (rd_valid_ff |-> rd_data_ff[1])
    else $error("bit one low");
  zero_bits_a: assert property (rd_valid_ff |-> !rd_data_ff[3] &&
    !rd_data_ff[5] && !rd_data_ff[15]) else $error("fixed bit set");
  rsvd_zero_a: assert property (rd_valid_ff |-> !rd_data_ff[63:22])
    else $error("reserved set");
  gp_fault_a: assert property (bad_lw |=> legacy_exception_fault_ff)
    else $error("no fault");
  rs_fault_a: assert property (bad_nw |=> reserved_field_fault_ff)
    else $error("no fault");
  steer_off_a: assert property (!legacy_mode |=> !steer_ff)
    else $error("steer on");
endmodule

/* bench/tb_legacy_flags_register.sv */
// testbench for the legacy flags register
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module tb_legacy_flags_register;
  import lfr_pkg::*;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  lfr_req_t req = '0;
  logic arith_upd = 1'h0;
  lfr_arith_t arith_in = '0;
  logic legacy_mode = 1'h0;
  logic [63:0] rd_data_ff;
  logic rd_valid_ff, legacy_exception_fault_ff, reserved_field_fault_ff;
  lfr_steer_t steer_ff;
  int err_count = 0, comparisons = 0, cyc = 0;
  lfr_legacy_flags i_dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .req(req),
    .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff),
    .legacy_exception_fault_ff(legacy_exception_fault_ff),
    .reserved_field_fault_ff(reserved_field_fault_ff),
    .arith_upd(arith_upd),
    .arith_in(arith_in),
    .legacy_mode(legacy_mode),
    .steer_ff(steer_ff)
  );
  always #2 core_clk = ~core_clk;
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic wr(input logic n, input logic [63:0] d, input logic [1:0] f);
    @(negedge core_clk) req = '{1'h1, 1'h0, n, d};
    @(negedge core_clk) req = '0;
    `CHK({reserved_field_fault_ff, legacy_exception_fault_ff}, f)
  endtask
  task automatic rd(input logic n, input logic [63:0] e);
    @(negedge core_clk) req = '{1'h0, 1'h1, n, 64'h0};
    @(negedge core_clk) req = '0;
    `CHK(rd_data_ff, e)
    `CHK(rd_valid_ff, 1'h1)
  endtask
  task automatic t_legacy;
    rd(1'h0, 64'h2);
    wr(1'h0, 64'h3F_FFFF, 2'h0);
    rd(1'h0, 64'h3F_7FD7);
    wr(1'h0, 64'h40_0000, 2'h1);
    rd(1'h0, 64'h3F_7FD7);
    $display("legacy test done");
  endtask
  task automatic t_native;
    wr(1'h1, 64'h1_0000_0000_0000, 2'h2);
    rd(1'h1, 64'h3F_7FD7);
    wr(1'h1, 64'hFFFF, 2'h0);
    rd(1'h1, 64'h7FD7);
    $display("native test done");
  endtask
  task automatic t_arith;
    wr(1'h0, 64'h0, 2'h0);
    legacy_mode = 1'h1;
    @(negedge core_clk) arith_upd = 1'h1;
    arith_in = '1;
    @(negedge core_clk) arith_upd = 1'h0;
    @(negedge core_clk) `CHK(steer_ff, 10'h3F0)
    rd(1'h0, 64'hCD7);
    legacy_mode = 1'h0;
    @(negedge core_clk) arith_upd = 1'h1;
    arith_in = '0;
    @(negedge core_clk) arith_upd = 1'h0;
    `CHK(steer_ff, 10'h0)
    rd(1'h1, 64'hCD7);
    legacy_mode = 1'h1;
    rd(1'h0, 64'hCD7);
    wr(1'h0, 64'h3300, 2'h0);
    `CHK(steer_ff, 10'h00F)
    $display("arith test done");
  endtask
  task automatic t_reset;
    @(negedge core_clk) rstn = 1'h0;
    repeat (2) @(negedge core_clk);
    rstn = 1'h1;
    `CHK(steer_ff, 10'h0)
    `CHK({rd_valid_ff, legacy_exception_fault_ff}, 2'h0)
    rd(1'h0, 64'h2);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    rstn = 1'h1;
    t_legacy();
    t_native();
    t_arith();
    t_reset();
    give_verdict();
  end
endmodule
bind lfr_legacy_flags lfr_legacy_flags_assertions i_chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .req(req),
  .rd_data_ff(rd_data_ff),
  .rd_valid_ff(rd_valid_ff),
  .legacy_exception_fault_ff(legacy_exception_fault_ff),
  .reserved_field_fault_ff(reserved_field_fault_ff),
  .arith_upd(arith_upd),
  .arith_in(arith_in),
  .legacy_mode(legacy_mode),
  .steer_ff(steer_ff)
);
